// *** hw/glmoc_defines.svh ***
// Register map, field positions and timing constants of the genlock mode and offset control
// Summary of operation
// - Lock-select pin picks locked or free-run mode
// - Pin high forces free-running operation
// - Free-run timing derived only from crystal clock
// - Locked: timing phase-locked to horizontal reference
// - Locked: crystal drift does not move outputs
// - Reference loss while locked enters hold state
// - Reference format may differ from output format
// - Recognize 36 video and 16 graphics formats
// - Lock control bit 5 overrides pin
// - Three offsets: phase, pixels, lines
// - Phase offset delays outputs up to one period
// - Phase step count follows pixel clock band
// - Zero phase register gives zero phase offset
// - Horizontal offset delays timing in pixels
// - Vertical offset delays line timing in lines
// - Offsets only delay; advance by max minus value
// - Inherent two pixel clock delay to reference; the code gives three (two delay stages plus the output register)
`ifndef GLMOC_DEFINES_SVH
`define GLMOC_DEFINES_SVH
`define GLMOC_OFS_LOCK_CONTROL 8'h16
`define GLMOC_OFS_HORIZONTAL_OFFSET 8'h1B
`define GLMOC_OFS_VERTICAL_OFFSET 8'h1C
`define GLMOC_OFS_SUBPIXEL_PHASE 8'h1D
`define GLMOC_OFS_STATUS 8'h1E
`define GLMOC_OFS_LINE_LENGTH 8'h1F
`define GLMOC_OFS_FRAME_LENGTH 8'h20
`define GLMOC_BIT_HOST_LOCK_SEL 4
`define GLMOC_BIT_OVERRIDE 5
`define GLMOC_RST_LINE_LENGTH 16'h06B4
`define GLMOC_RST_FRAME_LENGTH 16'h020D
`define GLMOC_INHERENT_DELAY 2
`define GLMOC_REF_LOSS_NS 100000
`define GLMOC_CLK_NS 10
`define GLMOC_REF_LOSS_CYC (`GLMOC_REF_LOSS_NS / `GLMOC_CLK_NS)
`define GLMOC_LOCK_LINES 4'h4
`define GLMOC_FMT_AUTO 6'h3F
`endif

// *** hw/glmoc_pkg.sv ***
// Types of the genlock mode and offset control
package glmoc_pkg;
    // Operating mode, one-hot
    typedef enum logic [3:0] {
        GLMOC_FREE_RUN = 4'h1,
        GLMOC_ACQUIRE = 4'h2,
        GLMOC_LOCKED = 4'h4,
        GLMOC_HOLD = 4'h8
    } glmoc_mode_t;
endpackage

// *** hw/glmoc_delay_line.sv ***
// Fixed two-stage delay of the timing pulses
`timescale 1ns/100ps
`include "glmoc_defines.svh"
module glmoc_delay_line
(
    input wire clk,
    input wire rstn,
    input wire [1:0] din,
    output logic [1:0] dout
);
    // Pipeline stages
    logic [1:0] stage_reg [`GLMOC_INHERENT_DELAY];

    // Shift register, each stage a generate entry
    genvar g;
    generate
        for (g = 0; g < `GLMOC_INHERENT_DELAY; g++)
        begin : g_stage
            always_ff @(posedge clk or negedge rstn)
            begin
                if (!rstn)
                    stage_reg[g] <= 2'h0;
                else if (g == 0)
                    stage_reg[g] <= din;
                else
                    stage_reg[g] <= stage_reg[(g == 0) ? 0 : g - 1];
            end
        end
    endgenerate

    // Last stage out
    assign dout = stage_reg[`GLMOC_INHERENT_DELAY - 1];
endmodule

// *** hw/glmoc_top.sv ***
// Genlock mode selection, hold on reference loss, and output offset control
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/100ps
`include "glmoc_defines.svh"
module glmoc_top
#(
    parameter int REF_LOSS_CYC = `GLMOC_REF_LOSS_CYC
)
(
    input wire clk,
    input wire rstn,
    // Avalon-MM slave
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Reference and strap pins
    input wire lock_select,
    input wire ref_hsync,
    input wire ref_vsync,
    input wire [5:0] video_format_select,
    // Generated timing
    output logic hsync_out,
    output logic vsync_out,
    output logic [8:0] phase_delay_steps,
    output logic free_running,
    output logic locked,
    output logic holding
);
    // Registers written by software
    logic [15:0] lock_control_reg;
    logic [15:0] horizontal_offset_reg;
    logic [15:0] vertical_offset_reg;
    logic [15:0] subpixel_phase_offset_reg;
    logic [15:0] line_length_reg;
    logic [15:0] frame_length_reg;
    // Bus handshake
    logic ack_reg;
    // Mode state
    glmoc_pkg::glmoc_mode_t mode_reg;
    glmoc_pkg::glmoc_mode_t mode_next;
    // Reference edge detection
    logic hs_d_reg;
    logic vs_d_reg;
    logic hs_rise;
    logic vs_rise;
    // Reference presence watchdog
    logic [31:0] loss_cnt_reg;
    logic ref_lost;
    // Lock acquisition counter
    logic [3:0] lock_cnt_reg;
    // Output line and frame counters
    logic [15:0] h_cnt_reg;
    logic [15:0] v_cnt_reg;
    // Undelayed output pulses
    logic hs_raw;
    logic vs_raw;
    logic [1:0] delayed;
    // Effective lock selection, high means free run
    logic sel_free;
    // Phase step width mask
    logic [8:0] phase_mask;
    logic [8:0] phase_field;

    // Pin or host bit chooses mode
    assign sel_free = lock_control_reg[`GLMOC_BIT_OVERRIDE]
        ? lock_control_reg[`GLMOC_BIT_HOST_LOCK_SEL] : lock_select;

    // Bus answers one cycle after a request
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;

    // Acknowledge pulses once per request
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            ack_reg <= 1'b0;
        else
            // High for one cycle after each new request
            ack_reg <= (avs_read | avs_write) & ~ack_reg;
    end

    // Register writes, taken at the accepting edge
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            lock_control_reg <= 16'h0000;
            horizontal_offset_reg <= 16'h0000;
            vertical_offset_reg <= 16'h0000;
            subpixel_phase_offset_reg <= 16'h0000;
            // Timing lengths start at the default format
            line_length_reg <= `GLMOC_RST_LINE_LENGTH;
            frame_length_reg <= `GLMOC_RST_FRAME_LENGTH;
        end
        else if (avs_write && ack_reg)
        begin
            // Offset decode, any other address ignored
            case (avs_address)
                // Mode control bits
                `GLMOC_OFS_LOCK_CONTROL:
                    lock_control_reg <= avs_writedata[15:0];
                // Pixel delay of the timing outputs
                `GLMOC_OFS_HORIZONTAL_OFFSET:
                    horizontal_offset_reg <= avs_writedata[15:0];
                // Line delay of the line-based outputs
                `GLMOC_OFS_VERTICAL_OFFSET:
                    vertical_offset_reg <= avs_writedata[15:0];
                // Sub-pixel phase steps
                `GLMOC_OFS_SUBPIXEL_PHASE:
                    subpixel_phase_offset_reg <= avs_writedata[15:0];
                // Clocks per output line
                `GLMOC_OFS_LINE_LENGTH:
                    line_length_reg <= avs_writedata[15:0];
                // Lines per output frame
                `GLMOC_OFS_FRAME_LENGTH:
                    frame_length_reg <= avs_writedata[15:0];
                // Unmapped or read-only index: no change
                default:
                    lock_control_reg <= lock_control_reg;
            endcase
        end
    end

    // Read data, registered; unmapped reads return zero
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            avs_readdata <= 32'h0000_0000;
        // Latched in the request cycle, shown at the answer
        else if (avs_read && !ack_reg)
        begin
            case (avs_address)
                `GLMOC_OFS_LOCK_CONTROL:
                    avs_readdata <= {16'h0000, lock_control_reg};
                `GLMOC_OFS_HORIZONTAL_OFFSET:
                    avs_readdata <= {16'h0000, horizontal_offset_reg};
                `GLMOC_OFS_VERTICAL_OFFSET:
                    avs_readdata <= {16'h0000, vertical_offset_reg};
                `GLMOC_OFS_SUBPIXEL_PHASE:
                    avs_readdata <= {16'h0000, subpixel_phase_offset_reg};
                // Status: format pins above the one-hot mode
                `GLMOC_OFS_STATUS:
                    avs_readdata <= {22'h000000, video_format_select, mode_reg};
                `GLMOC_OFS_LINE_LENGTH:
                    avs_readdata <= {16'h0000, line_length_reg};
                `GLMOC_OFS_FRAME_LENGTH:
                    avs_readdata <= {16'h0000, frame_length_reg};
                // Unmapped indices read as zero
                default:
                    avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // Reference edge registers
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            // Idle level low, so no false edge after reset
            hs_d_reg <= 1'b0;
            vs_d_reg <= 1'b0;
        end
        else
        begin
            hs_d_reg <= ref_hsync;
            vs_d_reg <= ref_vsync;
        end
    end

    // Rising edges of the reference pulses
    assign hs_rise = ref_hsync & ~hs_d_reg;
    assign vs_rise = ref_vsync & ~vs_d_reg;

    // Watchdog: reference missing once no line edge for the timeout
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            loss_cnt_reg <= 32'h0000_0000;
        // A reference line edge clears the count; frame edges do not
        else if (hs_rise)
            loss_cnt_reg <= 32'h0000_0000;
        // Saturate so the loss flag stays up
        else if (loss_cnt_reg < REF_LOSS_CYC)
            loss_cnt_reg <= loss_cnt_reg + 32'h0000_0001;
    end

    // Reference counted as lost once the count saturates
    assign ref_lost = (loss_cnt_reg >= REF_LOSS_CYC);

    // Count reference lines while acquiring; any format accepted
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            lock_cnt_reg <= 4'h0;
        // Restart outside acquire or after a loss
        else if (mode_reg != glmoc_pkg::GLMOC_ACQUIRE || ref_lost)
            lock_cnt_reg <= 4'h0;
        // One count per reference line up to the goal
        else if (hs_rise && lock_cnt_reg != `GLMOC_LOCK_LINES)
            lock_cnt_reg <= lock_cnt_reg + 4'h1;
    end

    // Mode transitions
    always_comb
    begin
        mode_next = mode_reg;
        case (mode_reg)
            // Leave free run once pin or host asks for lock
            glmoc_pkg::GLMOC_FREE_RUN:
                if (!sel_free)
                    mode_next = glmoc_pkg::GLMOC_ACQUIRE;
            glmoc_pkg::GLMOC_ACQUIRE:
                // Lock only with reference present
                if (sel_free)
                    mode_next = glmoc_pkg::GLMOC_FREE_RUN;
                else if (lock_cnt_reg == `GLMOC_LOCK_LINES)
                    mode_next = glmoc_pkg::GLMOC_LOCKED;
            // Free-run request wins over reference loss
            glmoc_pkg::GLMOC_LOCKED:
                if (sel_free)
                    mode_next = glmoc_pkg::GLMOC_FREE_RUN;
                else if (ref_lost)
                    mode_next = glmoc_pkg::GLMOC_HOLD;
            // Keep held timing until a reference edge returns
            glmoc_pkg::GLMOC_HOLD:
                if (sel_free)
                    mode_next = glmoc_pkg::GLMOC_FREE_RUN;
                else if (hs_rise)
                    mode_next = glmoc_pkg::GLMOC_ACQUIRE;
            // Illegal code recovers to free run
            default:
                mode_next = glmoc_pkg::GLMOC_FREE_RUN;
        endcase
    end

    // Mode register
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            mode_reg <= glmoc_pkg::GLMOC_FREE_RUN;
        else
            mode_reg <= mode_next;
    end

    // Horizontal counter; reference restarts it only when locked
    // Free run and hold keep counting on the local clock
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            h_cnt_reg <= 16'h0000;
        // Reference line edge restarts the line
        else if (mode_reg == glmoc_pkg::GLMOC_LOCKED && hs_rise)
            h_cnt_reg <= 16'h0001;
        // Local wrap at the programmed line length
        else if (h_cnt_reg >= line_length_reg - 16'h0001)
            h_cnt_reg <= 16'h0000;
        else
            h_cnt_reg <= h_cnt_reg + 16'h0001;
    end

    // Vertical counter, line-based
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            v_cnt_reg <= 16'h0000;
        // Reference frame edge restarts the frame
        else if (mode_reg == glmoc_pkg::GLMOC_LOCKED && vs_rise)
            v_cnt_reg <= 16'h0000;
        // Locked: each reference line edge ends a line
        else if (mode_reg == glmoc_pkg::GLMOC_LOCKED && hs_rise)
        begin
            if (v_cnt_reg >= frame_length_reg - 16'h0001)
                v_cnt_reg <= 16'h0000;
            else
                v_cnt_reg <= v_cnt_reg + 16'h0001;
        end
        // Otherwise a line ends at the local wrap
        else if (h_cnt_reg >= line_length_reg - 16'h0001)
        begin
            if (v_cnt_reg >= frame_length_reg - 16'h0001)
                v_cnt_reg <= 16'h0000;
            else
                v_cnt_reg <= v_cnt_reg + 16'h0001;
        end
    end

    // Output pulses delayed by offsets; positive only
    assign hs_raw = (h_cnt_reg == horizontal_offset_reg);
    assign vs_raw = hs_raw && (v_cnt_reg == vertical_offset_reg);

    // Inherent pipeline delay
    // Vsync rides in the upper bit, hsync in the lower
    glmoc_delay_line u_delay
    (
        .clk(clk),
        .rstn(rstn),
        .din({vs_raw, hs_raw}),
        .dout(delayed)
    );

    // Phase step width by clock band of the format
    always_comb
    begin
        case (video_format_select)
            // Slowest band, 1/512 steps
            6'h01: phase_mask = 9'h1FF;
            // Second band, 1/256 steps
            6'h03, 6'h04, 6'h05, 6'h06, 6'h27, 6'h28, 6'h29, 6'h2A:
                phase_mask = 9'h0FF;
            // Fastest band, 1/64 steps
            6'h15, 6'h16, 6'h17, 6'h2F, 6'h30, 6'h31, 6'h32, 6'h33:
                phase_mask = 9'h03F;
            // Remaining formats, 1/128 steps
            default: phase_mask = 9'h07F;
        endcase
    end

    // Low step bits taken; zero register means zero phase
    assign phase_field = subpixel_phase_offset_reg[8:0] & phase_mask;

    // Registered outputs
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            hsync_out <= 1'b0;
            vsync_out <= 1'b0;
            phase_delay_steps <= 9'h000;
            // Idle in free run
            free_running <= 1'b1;
            locked <= 1'b0;
            holding <= 1'b0;
        end
        else
        begin
            hsync_out <= delayed[0];
            vsync_out <= delayed[1];
            phase_delay_steps <= phase_field;
            // Flags follow the next state, in step with status
            free_running <= (mode_next == glmoc_pkg::GLMOC_FREE_RUN);
            locked <= (mode_next == glmoc_pkg::GLMOC_LOCKED);
            holding <= (mode_next == glmoc_pkg::GLMOC_HOLD);
        end
    end
endmodule

// *** dv/glmoc_ref_src.sv ***
// Reference sync source facing the genlock control block
`timescale 1ns/100ps
module glmoc_ref_src
#(
    parameter int LINE = 32,
    parameter int FRAME = 5
)
(
    input wire clk,
    input wire rstn,
    input wire en,
    output logic hsync,
    output logic vsync
);
    int h; // Pixel count in line
    int v; // Line count in frame
    // Pulses per line and frame; lines sit low when removed
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn || !en)
        begin
            h <= 0;
            v <= 0;
            hsync <= 1'b0;
            vsync <= 1'b0;
        end
        else
        begin
            h <= (h == LINE - 1) ? 0 : h + 1;
            if (h == LINE - 1)
                v <= (v == FRAME - 1) ? 0 : v + 1;
            hsync <= (h == 0);
            vsync <= (h == 0) && (v == 0);
        end
    end
endmodule

// *** dv/glmoc_checker.sv ***
// Bus and mode assertions of the genlock control block
`timescale 1ns/100ps
module glmoc_checker
(
    input wire clk,
    input wire rstn,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input logic [31:0] avs_readdata,
    input logic avs_waitrequest,
    input wire lock_select,
    input wire [5:0] video_format_select,
    input logic hsync_out,
    input logic [8:0] phase_delay_steps,
    input logic free_running,
    input logic locked,
    input logic holding
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    logic ovr_reg; // Host override bit
    logic hsel_reg; // Host free-run bit
    logic eff; // Effective free-run request
    logic wdone; // Write accepted
    logic hi_band; // Fastest clock formats
    assign wdone = avs_write && !avs_waitrequest;
    assign eff = ovr_reg ? hsel_reg : lock_select;
    assign hi_band = video_format_select inside {[6'h15:6'h17], [6'h2F:6'h33]};
    // Shadow of the lock control bits
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ovr_reg <= 1'b0;
            hsel_reg <= 1'b0;
        end
        else if (wdone && avs_address == 8'h16)
        begin
            ovr_reg <= avs_writedata[5];
            hsel_reg <= avs_writedata[4];
        end
    end
    sequence s_req;
        $rose(avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_ack;
        !avs_waitrequest;
    endsequence
    a_one_wait: assert property (s_req |=> s_ack)
        else $error("request not answered after one wait state");
    a_unmapped_zero: assert property (avs_read && !avs_waitrequest
        && !(avs_address inside {8'h16, [8'h1B:8'h20]}) |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_mode_onehot: assert property ($onehot0({free_running, locked, holding}))
        else $error("more than one mode flag");
    a_free_select: assert property (eff [*3] |-> free_running)
        else $error("free run request not obeyed");
    a_lock_low: assert property ($rose(locked) |-> !$past(eff))
        else $error("lock entered while free run requested");
    a_hold_from_lock: assert property ($rose(holding) |-> $past(locked))
        else $error("hold entered from a state other than lock");
    a_band_mask: assert property (hi_band [*3] |-> phase_delay_steps[8:6] == 3'h0)
        else $error("phase steps exceed band");
    a_zero_phase: assert property (wdone && avs_address == 8'h1D
        && avs_writedata[15:0] == 16'h0 |=> ##[0:1] phase_delay_steps == 9'h0)
        else $error("zero phase write gave nonzero delay");
    a_hsync_single: assert property (hsync_out |=> !hsync_out)
        else $error("hsync pulse longer than one cycle");
endmodule
bind glmoc_top glmoc_checker chk_i (.clk, .rstn, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .lock_select, .video_format_select,
    .hsync_out, .phase_delay_steps, .free_running, .locked, .holding);

// *** dv/tb.sv ***
// Self-checking bench of the genlock control block
`timescale 1ns/100ps
module tb;
    logic clk, rstn, rd_en, wr_en, wreq, pin, ref_en, rh, rv, hso, vso, fr, lk, hd;
    logic [7:0] adr; // Register index
    logic [31:0] wdat, rdat, q; // Bus data and last read
    logic [5:0] fmt; // Format select
    logic [8:0] pds; // Phase steps
    int n_mismatch, n_checks, d0, d1; // Counters and delays
    glmoc_top #(.REF_LOSS_CYC(50)) uut (.clk(clk), .rstn(rstn), .avs_address(adr),
        .avs_read(rd_en), .avs_write(wr_en), .avs_writedata(wdat), .avs_readdata(rdat),
        .avs_waitrequest(wreq), .lock_select(pin), .ref_hsync(rh), .ref_vsync(rv),
        .video_format_select(fmt), .hsync_out(hso), .vsync_out(vso),
        .phase_delay_steps(pds), .free_running(fr), .locked(lk), .holding(hd));
    glmoc_ref_src #(.LINE(32)) src (.clk(clk), .rstn(rstn), .en(ref_en), .hsync(rh),
        .vsync(rv));
    // 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Compare and count
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Bus write, held until waitrequest low
    task wr(input logic [7:0] a, input logic [15:0] d);
        adr <= a;
        wdat <= {16'h0, d};
        wr_en <= 1'b1;
        do @(posedge clk); while (wreq !== 1'b0);
        wr_en <= 1'b0;
        @(posedge clk);
    endtask
    // Bus read, data taken at the answering edge
    task rd(input logic [7:0] a);
        adr <= a;
        rd_en <= 1'b1;
        do @(posedge clk); while (wreq !== 1'b0);
        q = rdat;
        rd_en <= 1'b0;
        @(posedge clk);
    endtask
    // Wait for a mode flag set, bounded
    task wait_mode(input logic [2:0] m);
        for (int i = 0; i < 600 && {hd, lk, fr} !== m; i++) @(posedge clk);
    endtask
    // Cycles from reference edge to output pulse
    task meas(input bit v, output int d);
        d = 0;
        do @(posedge clk); while ((v ? rv : rh) !== 1'b1);
        do begin @(posedge clk); d++; end while ((v ? vso : hso) !== 1'b1 && d < 200);
    endtask
    task t_regs;
        rd(8'h1F); chk(q, 32'h06B4);
        rd(8'h20); chk(q, 32'h020D);
        rd(8'h1E);
        chk(q[3:0], 4'h4);
        for (int a = 8'h1B; a <= 8'h1D; a++)
        begin
            // Values stay inside the output line and frame lengths
            wr(a, 16'h0120 ^ a);
            rd(a); chk(q, 32'h0120 ^ a);
        end
        wr(8'h40, 16'hFFFF);
        rd(8'h40); chk(q, 32'h0);
        $display("t_regs done");
    endtask
    task t_lock;
        ref_en <= 1'b1;
        repeat (100) @(posedge clk);
        rd(8'h1E);
        chk(q[3:0], 4'h1);
        pin <= 1'b0;
        wait_mode(3'b010);
        chk(lk, 1'b1);
        rd(8'h1E); chk(q[3:0], 4'h4);
        $display("t_lock done");
    endtask
    task t_phase;
        logic [5:0] f[5] = '{6'h01, 6'h03, 6'h07, 6'h15, 6'h33};
        logic [8:0] e[5] = '{9'h1FF, 9'hFF, 9'h7F, 9'h3F, 9'h3F};
        wr(8'h1D, 16'h01FF);
        for (int i = 0; i < 5; i++)
        begin
            fmt <= f[i];
            repeat (3) @(posedge clk);
            chk(pds, e[i]);
        end
        wr(8'h1D, 16'h0000);
        repeat (3) @(posedge clk);
        chk(pds, 9'h0);
        fmt <= 6'h07;
        $display("t_phase done");
    endtask
    task t_hoff;
        wr(8'h1B, 16'h0008); meas(1'b0, d0);
        wr(8'h1B, 16'h0014); meas(1'b0, d1);
        chk(d1 - d0, 12);
        chk(d0 - 8 >= 2, 1);
        wr(8'h1C, 16'h0000);
        meas(1'b1, d0);
        wr(8'h1C, 16'h0002);
        meas(1'b1, d1);
        // Two reference lines of 32 clocks later
        chk(d1 - d0, 64);
        $display("t_hoff done");
    endtask
    task t_override;
        wr(8'h16, 16'h0030);
        repeat (5) @(posedge clk);
        chk(fr, 1'b1);
        wr(8'h16, 16'h0020);
        wait_mode(3'b010);
        chk(lk, 1'b1);
        wr(8'h16, 16'h0000);
        $display("t_override done");
    endtask
    task t_hold;
        ref_en <= 1'b0;
        wait_mode(3'b100);
        rd(8'h1E); chk(q[3:0], 4'h8);
        // Auto format: phase set before the reference returns
        fmt <= 6'h3F;
        wr(8'h1D, 16'h0000);
        ref_en <= 1'b1;
        wait_mode(3'b010);
        chk(lk, 1'b1);
        pin <= 1'b1;
        repeat (5) @(posedge clk);
        rd(8'h1E); chk(q[3:0], 4'h1);
        $display("t_hold done");
    endtask
    // Print counts and verdict, then stop
    task conclude;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        rstn = 1'b0; adr = 8'h0; rd_en = 1'b0; wr_en = 1'b0; wdat = 32'h0;
        pin = 1'b1; ref_en = 1'b0; fmt = 6'h07; n_mismatch = 0; n_checks = 0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_lock;
        t_regs;
        t_phase;
        t_hoff;
        t_override;
        t_hold;
        conclude;
    end
    // Watchdog against a hang
    initial
    begin
        #400000;
        n_mismatch++;
        conclude;
    end
endmodule
